//--- cfi_device_end.sv
// Device end: strips and decodes injection headers and merges both groups into the core.
// What this block does
// [R1] Two independent injection groups, ports 11 and 12.
// [R2] Core sees every injected frame from port 11.
// [R3] Precedence setting lets host beat front ports.
// [R4] First 20 bytes are the side-band header.
// [R5] Software enables header recognition per host port.
// [R6] Skip flag set: forward from header fields.
// [R7] Skip flag clear: normal analyzer lookups decide.
// [R8] Nine-bit command at 118, only when skipping.
// [R9] Low four bits zero: no rewrite.
// [R10] Low four bits eight: swap MACs, clear bit.
// [R11] Low three bits one: DSCP remark.
// [R12] Low three bits two: one-step PTP correction.
// [R13] Low three bits three: two-step timestamp store.
// [R14] Host two-step identifiers stay in 0..3.
// [R15] Low three bits five: write origin timestamp.
// [R16] Host zeroes undefined command bits.
// [R17] Rewrite value carries injection start time.
// [R18] Timer nonzero: value is slot 0..1023.
// [R19] Four-bit timer select at bit 37.
// [R20] Twelve-bit destination mask at bit 57.
// [R21] Four-bit source port at bit 43.
// [R22] Bit 127 is first byte's top bit.
// [R23] Skip clear: ignore command and mask.
`timescale 1ns/1ns
module cfi_device_end
	import cfi_pkg::*;
(
	input  wire logic               mclk_in,
	input  wire logic               rst_b_in,
	cfi_if.device                   link,
	input  wire logic               host_port_precedence_enable_in,
	input  wire logic               front_req_in,
	output logic                    front_grant_out,
	output logic                    core_desc_valid_out,
	output logic [3:0]              core_ingress_port_number_out,
	output logic [3:0]              core_phys_port_out,
	output logic                    core_bypass_out,
	output logic                    core_analyze_out,
	output logic [MASK_W-1:0]       core_fwd_mask_out,
	output logic [HOSTQ_W-1:0]      core_host_queue_out,
	output logic [PRIO_W-1:0]       core_prio_out,
	output cfi_rewrite_t            core_rewrite_op_out,
	output logic [ARG_W-1:0]        core_rewrite_arg_out,
	output logic                    core_egress_delay_out,
	output logic [VAL_W-1:0]        core_rewrite_value_out,
	output logic [TIMER_W-1:0]      core_timer_out,
	output logic                    core_slot_valid_out,
	output logic [SLOT_W-1:0]       core_slot_out,
	output logic [PORT_W-1:0]       core_ingress_port_out,
	output logic                    core_valid_out,
	output logic [7:0]              core_data_out,
	output logic                    core_last_out,
	input  wire logic               core_ready_in
);
	function automatic cfi_rewrite_t decode_cmd(input logic [CMD_W-1:0] cmd);
		cfi_rewrite_t op;
		op = RW_NONE;
		if (cmd[3:0] == CMD4_NOP) begin
			op = RW_NONE; // R9
		end else if (cmd[3:0] == CMD4_SWAP) begin
			op = RW_SWAP; // R10
		end else begin
			case (cmd[2:0])
				CMD3_DSCP:     op = RW_DSCP; // R11
				CMD3_PTP_ONE:  op = RW_PTP_ONE; // R12
				CMD3_PTP_TWO:  op = RW_PTP_TWO; // R13
				CMD3_PTP_ORIG: op = RW_PTP_ORIG; // R15
				default:       op = RW_NONE;
			endcase
		end
		return op;
	endfunction : decode_cmd

	cfi_gstate_t         st_q  [GROUPS];
	logic [CNT_W-1:0]    cnt_q [GROUPS];
	logic [HDR_BITS-1:0] hdr_q [GROUPS];
	logic [1:0]          pend;
	logic [1:0]          acc;
	logic                owner_q;
	logic                owner_act_q;
	logic                rr_q;
	logic                last_host_q;
	logic                pick;
	logic                take_host;
	logic                out_free;
	logic [HDR_BITS-1:0] hsel;
	logic [CMD_W-1:0]    cmd;
	logic                skip;

	assign out_free = !core_valid_out || core_ready_in;

	always_comb begin
		for (int g = 0; g < GROUPS; g++) begin
			pend[g] = (st_q[g] == GS_WAIT);
			link.inj_ready[g] = ((st_q[g] == GS_HDR) && link.inj_hdr_en[g]) || // R5
				((st_q[g] == GS_BODY) && owner_act_q && (owner_q == 1'(g)) && out_free);
			acc[g] = link.inj_valid[g] && link.inj_ready[g];
		end
	end

	// Each group runs on its own; neither waits for the other's header. R1
	generate
		for (genvar g = 0; g < GROUPS; g++) begin : g_grp
			always_ff @(posedge mclk_in or negedge rst_b_in) begin
				if (!rst_b_in) begin
					st_q[g]  <= GS_HDR;
					cnt_q[g] <= '0;
					hdr_q[g] <= '0;
				end else begin
					case (st_q[g])
						GS_HDR: begin
							if (!link.inj_hdr_en[g]) begin
								if (link.inj_valid[g]) begin
									hdr_q[g] <= '0; // R7
									st_q[g]  <= GS_WAIT;
								end
							end else if (acc[g]) begin
								hdr_q[g] <= {hdr_q[g][HDR_BITS-9:0], link.inj_data[g]}; // R22
								if (link.inj_last[g]) begin
									cnt_q[g] <= '0;
								end else if (cnt_q[g] == CNT_W'(HDR_BYTES - 1)) begin
									cnt_q[g] <= '0; // R4
									st_q[g]  <= GS_WAIT;
								end else begin
									cnt_q[g] <= cnt_q[g] + 1'b1;
								end
							end
						end
						GS_WAIT: begin
							if (take_host && (pick == 1'(g))) begin
								st_q[g] <= GS_BODY;
							end
						end
						GS_BODY: begin
							if (acc[g] && link.inj_last[g]) begin
								st_q[g] <= GS_HDR;
							end
						end
						default: st_q[g] <= GS_HDR;
					endcase
				end
			end
		end
	endgenerate

	always_comb begin
		pick = (pend[0] && pend[1]) ? rr_q : pend[1];
		take_host = (|pend) && !owner_act_q &&
			(!front_req_in || host_port_precedence_enable_in || !last_host_q); // R3
		front_grant_out = front_req_in && !take_host;
		hsel = hdr_q[pick];
		skip = hsel[HDR_BASE + BYPASS_POS];
		cmd = hsel[HDR_BASE + CMD_POS +: CMD_W]; // R8
	end

	always_ff @(posedge mclk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			owner_q     <= 1'b0;
			owner_act_q <= 1'b0;
			rr_q        <= 1'b0;
			last_host_q <= 1'b0;
		end else begin
			if (take_host) begin
				owner_q     <= pick;
				owner_act_q <= 1'b1;
				rr_q        <= !pick;
				last_host_q <= 1'b1;
			end else begin
				if (front_grant_out) begin
					last_host_q <= 1'b0;
				end
				if (owner_act_q && acc[owner_q] && link.inj_last[owner_q]) begin
					owner_act_q <= 1'b0;
				end
			end
		end
	end

	always_ff @(posedge mclk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			core_desc_valid_out    <= 1'b0;
			core_ingress_port_number_out      <= HOST_PORT;
			core_phys_port_out     <= HOST_PORT;
			core_bypass_out        <= 1'b0;
			core_analyze_out       <= 1'b0;
			core_fwd_mask_out      <= '0;
			core_host_queue_out    <= '0;
			core_prio_out          <= '0;
			core_rewrite_op_out    <= RW_NONE;
			core_rewrite_arg_out   <= '0;
			core_egress_delay_out  <= 1'b0;
			core_rewrite_value_out <= '0;
			core_timer_out         <= '0;
			core_slot_valid_out    <= 1'b0;
			core_slot_out          <= '0;
			core_ingress_port_out  <= '0;
		end else begin
			core_desc_valid_out <= take_host;
			if (take_host) begin
				core_ingress_port_number_out   <= HOST_PORT; // R2
				core_phys_port_out  <= pick ? HOST_PORT_ALT : HOST_PORT; // R1
				core_bypass_out     <= skip; // R6
				core_analyze_out    <= !skip; // R7
				core_fwd_mask_out   <= skip ? hsel[HDR_BASE + MASK_POS +: MASK_W] : '0; // R20 R23
				core_host_queue_out <= skip ? hsel[HDR_BASE + HOSTQ_POS +: HOSTQ_W] : '0; // R6
				core_prio_out       <= skip ? hsel[HDR_BASE + PRIO_POS +: PRIO_W] : '0; // R6
				core_rewrite_op_out <= skip ? decode_cmd(cmd) : RW_NONE; // R8 R23
				core_rewrite_arg_out <= skip ? cmd[CMD_W-1:3] : '0; // R11 R13
				core_egress_delay_out <= skip && (decode_cmd(cmd) == RW_PTP_ONE) &&
					cmd[DELAY_BIT]; // R12
				core_rewrite_value_out <= hsel[HDR_BASE + VAL_POS +: VAL_W]; // R17
				core_timer_out <= hsel[HDR_BASE + TIMER_POS +: TIMER_W]; // R19
				core_slot_valid_out <= (hsel[HDR_BASE + TIMER_POS +: TIMER_W] != '0); // R18
				core_slot_out <= hsel[HDR_BASE + VAL_POS +: SLOT_W]; // R18
				core_ingress_port_out <= hsel[HDR_BASE + PORT_POS +: PORT_W]; // R21
			end
		end
	end

	always_ff @(posedge mclk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			core_valid_out <= 1'b0;
			core_data_out  <= '0;
			core_last_out  <= 1'b0;
		end else if (out_free) begin
			core_valid_out <= owner_act_q && acc[owner_q];
			if (owner_act_q && acc[owner_q]) begin
				core_data_out <= link.inj_data[owner_q];
				core_last_out <= link.inj_last[owner_q];
			end
		end
	end
endmodule : cfi_device_end

//--- cfi_host_end.sv
// Host end: APB-programmed writer that sends header and payload into one injection group.
`timescale 1ns/1ns
module cfi_host_end
	import cfi_pkg::*;
(
	input  wire logic        mclk_in,
	input  wire logic        rst_b_in,
	cfi_if.host              link,
	input  wire logic        psel_in,
	input  wire logic        penable_in,
	input  wire logic        pwrite_in,
	input  wire logic [11:0] paddr_in,
	input  wire logic [31:0] pwdata_in,
	output logic [31:0]      prdata_out,
	output logic             pready_out,
	output logic             pslverr_out
);
	function automatic logic [CMD_W-1:0] clean_cmd(input logic [CMD_W-1:0] c);
		logic [CMD_W-1:0] r;
		r = '0;
		if (c[3:0] == CMD4_SWAP) begin
			r[3:0] = c[3:0];
		end else if (c[3:0] != CMD4_NOP) begin
			case (c[2:0])
				CMD3_DSCP:     r = c;
				CMD3_PTP_ONE:  r = {3'h0, c[DELAY_BIT], 2'h0, c[2:0]};
				CMD3_PTP_TWO:  r = {4'h0, c[4:3] & HOST_TS_ID_MSK, c[2:0]}; // R14
				CMD3_PTP_ORIG: r[2:0] = c[2:0];
				default:       r = '0;
			endcase
		end
		return r;
	endfunction : clean_cmd

	cfi_hstate_t         st_q;
	logic [31:0]         hdr_word_q [5];
	logic                grp_q;
	logic [1:0]          en_q;
	logic [CNT_W-1:0]    idx_q;
	logic                out_valid_q;
	logic [7:0]          out_data_q;
	logic                out_last_q;
	logic [HDR_BITS-1:0] view;
	logic                access;
	logic                data_wr;
	logic                sent;
	logic                done;
	logic                mapped;

	always_comb begin
		view = {hdr_word_q[0], hdr_word_q[1], hdr_word_q[2], hdr_word_q[3], hdr_word_q[4]};
		view[HDR_BASE + CMD_POS +: CMD_W] = clean_cmd(view[HDR_BASE + CMD_POS +: CMD_W]); // R16
		access  = psel_in && penable_in;
		data_wr = pwrite_in && (paddr_in == REG_DATA);
		sent    = out_valid_q && link.inj_ready[grp_q];
		mapped  = (paddr_in <= REG_STATUS) && (paddr_in[1:0] == 2'h0);
		pready_out  = (access && data_wr && (st_q == HS_BODY)) ? sent : 1'b1;
		pslverr_out = access && (!mapped || (data_wr && (st_q != HS_BODY)));
		done = access && pready_out;
		link.inj_hdr_en = en_q; // R5
		link.inj_valid  = {out_valid_q && grp_q, out_valid_q && !grp_q};
		link.inj_last   = {2{out_last_q}};
		link.inj_data   = {2{out_data_q}};
	end

	always_ff @(posedge mclk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			for (int i = 0; i < 5; i++) begin
				hdr_word_q[i] <= '0;
			end
			grp_q <= 1'b0;
			en_q  <= '0;
		end else if (done && pwrite_in && mapped) begin
			if (paddr_in <= REG_HDR4) begin
				hdr_word_q[paddr_in[4:2]] <= pwdata_in; // R17
			end else if ((paddr_in == REG_CTRL) && (st_q == HS_IDLE)) begin
				grp_q <= pwdata_in[CTRL_GRP_BIT];
				en_q  <= {pwdata_in[CTRL_EN1_BIT], pwdata_in[CTRL_EN0_BIT]};
			end
		end
	end

	always_ff @(posedge mclk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			st_q        <= HS_IDLE;
			idx_q       <= '0;
			out_valid_q <= 1'b0;
			out_data_q  <= '0;
			out_last_q  <= 1'b0;
		end else begin
			case (st_q)
				HS_IDLE: begin
					if (done && pwrite_in && (paddr_in == REG_CTRL) &&
							pwdata_in[CTRL_START_BIT] &&
							pwdata_in[CTRL_EN0_BIT + 32'(pwdata_in[CTRL_GRP_BIT])]) begin
						st_q  <= HS_HDR; // R5
						idx_q <= '0;
					end
				end
				HS_HDR: begin
					if (!out_valid_q || sent) begin
						if (idx_q == CNT_W'(HDR_BYTES)) begin
							out_valid_q <= 1'b0;
							st_q        <= HS_BODY; // R4
						end else begin
							out_valid_q <= 1'b1;
							out_last_q  <= 1'b0;
							out_data_q  <= view[(HDR_BITS - 1 - 8 * idx_q) -: 8]; // R22
							idx_q       <= idx_q + 1'b1;
						end
					end
				end
				HS_BODY: begin
					if (sent) begin
						out_valid_q <= 1'b0;
						if (out_last_q) begin
							st_q <= HS_IDLE;
						end
					end else if (access && data_wr && !out_valid_q) begin
						out_valid_q <= 1'b1;
						out_data_q  <= pwdata_in[7:0];
						out_last_q  <= pwdata_in[DATA_LAST_BIT];
					end
				end
				default: st_q <= HS_IDLE;
			endcase
		end
	end

	always_comb begin
		prdata_out = '0;
		if (access && !pwrite_in) begin
			if (paddr_in <= REG_HDR4) begin
				prdata_out = hdr_word_q[paddr_in[4:2]];
			end else if (paddr_in == REG_CTRL) begin
				prdata_out = {28'h0, en_q, 1'b0, grp_q};
			end else if (paddr_in == REG_STATUS) begin
				prdata_out = {29'h0, out_valid_q, st_q == HS_BODY, st_q == HS_HDR};
			end
		end
	end
endmodule : cfi_host_end

//--- cfi_if.sv
// Byte stream link of the two injection groups between host and device.
`timescale 1ns/1ns
interface cfi_if;
	logic [1:0]      inj_hdr_en;
	logic [1:0]      inj_valid;
	logic [1:0]      inj_last;
	logic [1:0][7:0] inj_data;
	logic [1:0]      inj_ready;
	modport host   (output inj_hdr_en, output inj_valid, output inj_last,
			output inj_data, input inj_ready);
	modport device (input inj_hdr_en, input inj_valid, input inj_last,
			input inj_data, output inj_ready);
endinterface : cfi_if

//--- cfi_pkg.sv
// Shared constants and types for the host frame injection header path.
package cfi_pkg;
	localparam int GROUPS    = 2;
	localparam int HDR_BYTES = 20;
	localparam int HDR_BITS  = 160;
	localparam int HDR_BASE  = 32;
	localparam int CNT_W     = 5;

	localparam int BYPASS_POS  = 127;
	localparam int CMD_POS     = 118;
	localparam int CMD_W       = 9;
	localparam int VAL_POS     = 86;
	localparam int VAL_W       = 32;
	localparam int MASK_POS    = 57;
	localparam int MASK_W      = 12;
	localparam int PORT_POS    = 43;
	localparam int PORT_W      = 4;
	localparam int TIMER_POS   = 37;
	localparam int TIMER_W     = 4;
	localparam int HOSTQ_POS   = 20;
	localparam int HOSTQ_W     = 8;
	localparam int PRIO_POS    = 17;
	localparam int PRIO_W      = 3;
	localparam int SLOT_W      = 10;
	localparam int ARG_W       = 6;
	localparam int DELAY_BIT   = 5;
	localparam int SMAC_CLR_BIT = 40;

	localparam logic [3:0] HOST_PORT      = 4'hB;
	localparam logic [3:0] HOST_PORT_ALT  = 4'hC;
	localparam logic [3:0] CMD4_NOP       = 4'h0;
	localparam logic [3:0] CMD4_SWAP      = 4'h8;
	localparam logic [2:0] CMD3_DSCP      = 3'h1;
	localparam logic [2:0] CMD3_PTP_ONE   = 3'h2;
	localparam logic [2:0] CMD3_PTP_TWO   = 3'h3;
	localparam logic [2:0] CMD3_PTP_ORIG  = 3'h5;
	localparam logic [1:0] HOST_TS_ID_MSK = 2'h3;

	localparam logic [11:0] REG_HDR0   = 12'h000;
	localparam logic [11:0] REG_HDR4   = 12'h010;
	localparam logic [11:0] REG_CTRL   = 12'h014;
	localparam logic [11:0] REG_DATA   = 12'h018;
	localparam logic [11:0] REG_STATUS = 12'h01C;
	localparam int CTRL_GRP_BIT   = 0;
	localparam int CTRL_START_BIT = 1;
	localparam int CTRL_EN0_BIT   = 2;
	localparam int CTRL_EN1_BIT   = 3;
	localparam int DATA_LAST_BIT  = 8;

	typedef enum logic [5:0] {
		RW_NONE     = 6'b000001,
		RW_SWAP     = 6'b000010,
		RW_DSCP     = 6'b000100,
		RW_PTP_ONE  = 6'b001000,
		RW_PTP_TWO  = 6'b010000,
		RW_PTP_ORIG = 6'b100000
	} cfi_rewrite_t;

	typedef enum logic [2:0] {
		GS_HDR  = 3'b001,
		GS_WAIT = 3'b010,
		GS_BODY = 3'b100
	} cfi_gstate_t;

	typedef enum logic [2:0] {
		HS_IDLE = 3'b001,
		HS_HDR  = 3'b010,
		HS_BODY = 3'b100
	} cfi_hstate_t;
endpackage : cfi_pkg

//--- cfi_props.sv
// Concurrent checks on the injection link and the core descriptor outputs.
`timescale 1ns/1ns
module cfi_props
	import cfi_pkg::*;
(
	input wire logic                 mclk_in,
	input wire logic                 rst_b_in,
	input wire logic [1:0]           inj_hdr_en,
	input wire logic [1:0]           inj_valid,
	input wire logic [1:0]           inj_last,
	input wire logic [1:0][7:0]      inj_data,
	input wire logic [1:0]           inj_ready,
	input wire logic                 front_req_in,
	input wire logic                 front_grant_out,
	input wire logic                 core_desc_valid_out,
	input wire logic [3:0]           core_ingress_port_number_out,
	input wire logic                 core_bypass_out,
	input wire logic                 core_analyze_out,
	input wire logic [MASK_W-1:0]    core_fwd_mask_out,
	input wire cfi_rewrite_t         core_rewrite_op_out,
	input wire logic [TIMER_W-1:0]   core_timer_out,
	input wire logic                 core_slot_valid_out,
	input wire logic                 host_port_precedence_enable_in
);
	logic       take;
	logic [4:0] cnt_q;
	assign take = |(inj_valid & inj_ready);
	// Counts bytes taken in the current frame, saturating past the header.
	always_ff @(posedge mclk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			cnt_q <= 5'h00;
		end else if (take) begin
			cnt_q <= (|(inj_valid & inj_last)) ? 5'h00 : ((cnt_q == 5'h14) ? cnt_q : cnt_q + 5'h01);
		end
	end
	default clocking cb @(posedge mclk_in); endclocking
	default disable iff (!rst_b_in);
	sequence hdr_done;
		take && cnt_q == 5'h13 && (|(inj_hdr_en & inj_valid));
	endsequence
	a_hdr_pause: assert property (hdr_done |=> (inj_ready & $past(inj_valid)) == 2'b00)
		else $error("Ready stayed high after the header.");
	a_hdr_desc: assert property (hdr_done |-> ##[2:60] core_desc_valid_out)
		else $error("No descriptor after the header.");
	a_req_hold: assert property (inj_valid[0] && !inj_ready[0] |=> inj_valid[0] && $stable(inj_data[0]))
		else $error("Link byte changed before it was taken.");
	a_one_group: assert property ($onehot0(inj_valid))
		else $error("Both groups valid at once.");
	a_ingress_port_number: assert property (core_desc_valid_out |-> core_ingress_port_number_out == HOST_PORT)
		else $error("Core source port is not the host port.");
	a_analyze_inv: assert property (core_desc_valid_out |-> core_analyze_out == !core_bypass_out)
		else $error("Analyze flag does not mirror the skip flag.");
	a_skip_clear: assert property (core_desc_valid_out && !core_bypass_out |-> core_fwd_mask_out == 12'h000 && core_rewrite_op_out == RW_NONE)
		else $error("Host fields used on an analyzed frame.");
	a_slot_flag: assert property (core_desc_valid_out |-> core_slot_valid_out == (core_timer_out != 4'h0))
		else $error("Slot flag does not follow the timer select.");
	a_grant_req: assert property (front_grant_out |-> front_req_in ##1 !core_desc_valid_out)
		else $error("Front grant shared a cycle with a host grant.");
	a_host_first: assert property (hdr_done && host_port_precedence_enable_in |-> ##2 core_desc_valid_out)
		else $error("Host port lost arbitration with precedence on.");
	a_desc_pulse: assert property (core_desc_valid_out |=> !core_desc_valid_out)
		else $error("Descriptor strobe longer than one cycle.");
endmodule : cfi_props

//--- cpu_frame_injection_header_test.sv
// Self-checking bench: the host end writes frames over APB and the device end decodes them.
`timescale 1ns/1ns
module cpu_frame_injection_header_test;
	import cfi_pkg::*;
	logic         mclk_in, rst_b_in, psel, penable, pwrite, pready, pslverr;
	logic [11:0]  paddr, fmask;
	logic [31:0]  pwdata, prdata, rval;
	logic         prec, freq, cready, fgnt, dv, byp, ana, dly, slv, cv, cl, last_f;
	logic [3:0]   src_p, phys_p, tmr, in_port;
	logic [5:0]   rarg;
	logic [2:0]   prio;
	logic [9:0]   slot;
	logic [7:0]   cdata, first_b, last_b, hq;
	cfi_rewrite_t rop;
	logic         sof = 1'b1;
	int           desc_n = 0;
	int           miscompares = 0;
	int           checks_done = 0;
	logic [8:0]   cmds [7] = '{9'h000, 9'h008, 9'h151, 9'h022, 9'h0F3, 9'h1F5, 9'h008};
	logic [5:0]   args [7] = '{6'h00, 6'h01, 6'h2A, 6'h04, 6'h02, 6'h00, 6'h01};
	cfi_rewrite_t ops [7] = '{RW_NONE, RW_SWAP, RW_DSCP, RW_PTP_ONE, RW_PTP_TWO, RW_PTP_ORIG, RW_NONE};

	cfi_if u_link();
	cfi_host_end u_cfi_host_end(.mclk_in(mclk_in), .rst_b_in(rst_b_in), .link(u_link.host),
		.psel_in(psel), .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr),
		.pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr));
	cfi_device_end u_cfi_device_end(.mclk_in(mclk_in), .rst_b_in(rst_b_in), .link(u_link.device),
		.host_port_precedence_enable_in(prec), .front_req_in(freq), .front_grant_out(fgnt),
		.core_desc_valid_out(dv), .core_ingress_port_number_out(src_p), .core_phys_port_out(phys_p),
		.core_bypass_out(byp), .core_analyze_out(ana), .core_fwd_mask_out(fmask),
		.core_host_queue_out(hq), .core_prio_out(prio), .core_rewrite_op_out(rop),
		.core_rewrite_arg_out(rarg), .core_egress_delay_out(dly), .core_rewrite_value_out(rval),
		.core_timer_out(tmr), .core_slot_valid_out(slv), .core_slot_out(slot),
		.core_ingress_port_out(in_port), .core_valid_out(cv), .core_data_out(cdata),
		.core_last_out(cl), .core_ready_in(cready));
	cfi_props u_cfi_props(.mclk_in(mclk_in), .rst_b_in(rst_b_in), .inj_hdr_en(u_link.inj_hdr_en),
		.inj_valid(u_link.inj_valid), .inj_last(u_link.inj_last), .inj_data(u_link.inj_data),
		.inj_ready(u_link.inj_ready), .front_req_in(freq), .front_grant_out(fgnt),
		.core_desc_valid_out(dv), .core_ingress_port_number_out(src_p), .core_bypass_out(byp),
		.core_analyze_out(ana), .core_fwd_mask_out(fmask), .core_rewrite_op_out(rop),
		.core_timer_out(tmr), .core_slot_valid_out(slv),
		.host_port_precedence_enable_in(prec));

	initial begin
		mclk_in = 1'b0;
		forever #50 mclk_in = ~mclk_in;
	end

	// Stalls the core side every other cycle during some frames.
	always @(posedge mclk_in) begin
		cready <= (desc_n % 3 != 1) || !cready;
	end

	// Records descriptor strobes, the first link byte of each frame and the last core byte.
	always @(posedge mclk_in) begin
		if (dv === 1'b1) desc_n <= desc_n + 1;
		if (cv === 1'b1 && cready) begin
			last_b <= cdata;
			last_f <= cl;
		end
		if (|(u_link.inj_valid & u_link.inj_ready)) begin
			if (sof) first_b <= u_link.inj_data[0];
			sof <= |(u_link.inj_valid & u_link.inj_last);
		end
	end

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			miscompares++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
			output logic [31:0] rd, output logic err);
		@(posedge mclk_in);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk_in);
		penable <= 1'b1;
		do @(posedge mclk_in); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic frame(input logic g, input logic [127:0] h, input logic [7:0] b1);
		logic [31:0] r;
		logic        e;
		int          n;
		for (int k = 0; k < 4; k++) apb(1'b1, 12'(4 * k), h[127 - 32 * k -: 32], r, e);
		apb(1'b1, REG_HDR4, 32'h0, r, e);
		apb(1'b1, REG_CTRL, {28'h0, 3'h7, g}, r, e);
		n = 0;
		r = 32'h0;
		while (r[1] !== 1'b1 && n < 100) begin
			apb(1'b0, REG_STATUS, 32'h0, r, e);
			n++;
		end
		chk(r[1], 1'b1);
		apb(1'b1, REG_DATA, 32'h0000005A, r, e);
		apb(1'b1, REG_DATA, {23'h0, 1'b1, b1}, r, e);
		repeat (3) @(posedge mclk_in);
	endtask : frame

	task automatic final_report();
		$display("Checks %0d, mismatches %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : final_report

	initial begin
		repeat (20000) @(posedge mclk_in);
		miscompares++;
		final_report();
	end

	initial begin
		logic [127:0] h;
		logic [31:0]  r;
		logic         e;
		int           n0;
		rst_b_in = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
		prec = 1'b0;
		freq = 1'b0;
		repeat (16) @(posedge mclk_in);
		rst_b_in <= 1'b1;
		apb(1'b0, 12'h020, 32'h0, r, e);
		chk(e, 1'b1);
		apb(1'b1, REG_DATA, 32'h00000155, r, e);
		chk(e, 1'b1);
		apb(1'b1, REG_CTRL, 32'h00000002, r, e);
		apb(1'b0, REG_STATUS, 32'h0, r, e);
		chk(r, 32'h0);
		for (int i = 0; i < 7; i++) begin
			h = '0;
			h[127] = (i < 6);
			h[126:118] = cmds[i];
			h[117:86] = 32'h800003F0 + 32'(i);
			h[68:57] = 12'h800 | 12'(i);
			h[46:43] = 4'(i);
			h[27:20] = 8'h10 + 8'(i);
			h[19:17] = 3'(i);
			h[40:37] = 4'(i % 3);
			freq <= i[0];
			prec <= i[1];
			n0 = desc_n;
			frame(i[0], h, 8'hC0 + 8'(i));
			chk(desc_n - n0, 1);
			chk(phys_p, i[0] ? HOST_PORT_ALT : HOST_PORT);
			chk(src_p, HOST_PORT);
			chk(byp, h[127]);
			chk(ana, !h[127]);
			chk(fmask, (i < 6) ? h[68:57] : 12'h000);
			chk(rop, ops[i]);
			chk(first_b, {h[127], args[i], cmds[i][2]});
			chk(hq, (i < 6) ? h[27:20] : 8'h00);
			chk(prio, (i < 6) ? h[19:17] : 3'h0);
			chk(rarg, (i < 6) ? args[i] : 6'h00);
			chk(dly, i == 3);
			chk({last_f, last_b}, {1'b1, 8'hC0 + 8'(i)});
			if (i < 6) begin
				chk(rarg, args[i]);
				chk(rval, h[117:86]);
				chk(tmr, h[40:37]);
				chk({slv, slot}, {(i % 3) != 0, h[95:86]});
				chk(in_port, h[46:43]);
			end
		end
		final_report();
	end
endmodule : cpu_frame_injection_header_test
